// [bench/eee_link_properties.sv]
// Link checker: timing and flag relations between host and emulated EEPROM device
module eee_link_properties #(
	parameter int ERASE_PROG_CYCLES = 60 // Longest store time in cycles
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic bus_req,
	input wire logic bus_wr,
	input wire logic [1:0] bus_size,
	input wire logic [31:0] bus_addr,
	input wire logic bus_rsp,
	input wire logic bus_err,
	input wire logic cmd_valid,
	input wire logic irq_en,
	input wire logic emulation_ready_flag,
	input wire logic command_complete_flag,
	input wire logic cc_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	// Store bound, with room for the answer cycle
	localparam int WR_LIM = ERASE_PROG_CYCLES + 2;
	default clocking dclk @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	// Write aimed at the RAM window region
	wire logic win_wr;
	assign win_wr = bus_req && bus_wr && (bus_addr[31:26] == eee_pkg::WIN_REGION);
	// Aligned word read of program flash
	wire logic pf_rd;
	assign pf_rd = bus_req && !bus_wr && (bus_addr[31:12] == 20'h0) && (bus_addr[1:0] == 2'h0)
		&& (bus_size == eee_pkg::SZ_WORD);
	chk_rsp_follow: assert property (bus_req |=> bus_rsp)
		else $error("answer missing after request");
	chk_rsp_cause: assert property (bus_rsp |-> $past(bus_req))
		else $error("answer without request");
	chk_far_window: assert property (
		bus_req && bus_addr[31:26] == eee_pkg::WIN_REGION && bus_addr[25:12] != 14'h0 |=> bus_err)
		else $error("far window access not refused");
	chk_pf_read: assert property (pf_rd |=> bus_rsp && !bus_err)
		else $error("program flash read refused");
	chk_flags_drop: assert property (
		win_wr ##1 (bus_rsp && !bus_err) |-> (!command_complete_flag && !emulation_ready_flag)[*8])
		else $error("flags high during store");
	chk_write_bound: assert property (
		win_wr ##1 (bus_rsp && !bus_err) |-> ##[1:WR_LIM] command_complete_flag)
		else $error("store took too long");
	chk_read_quiet: assert property (
		bus_req && !bus_wr && command_complete_flag && !cmd_valid |=> command_complete_flag)
		else $error("read started a flash operation");
	chk_ready_idle: assert property (emulation_ready_flag |-> command_complete_flag)
		else $error("ready while operation runs");
	chk_cmd_taken: assert property (cmd_valid && command_complete_flag |=> !command_complete_flag)
		else $error("command not taken");
	chk_irq_gate: assert property (cc_irq |-> command_complete_flag)
		else $error("interrupt without command complete");
	chk_irq_raise: assert property (
		command_complete_flag && irq_en && $past(irq_en) |-> cc_irq)
		else $error("interrupt missing");
endmodule // eee_link_properties

// [bench/emulated_eeprom_access_tb.sv]
// Bench: host and device joined by the link, driven through the host register port
module emulated_eeprom_access_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LONG_SIM = 60; // Erase plus program cycles in simulation
	logic sys_clk, reset_n, factory_blank, pf_load_we, busy, reg_wr, reg_rd;
	logic [9:0] pf_load_addr;
	logic [7:0] reg_addr;
	logic [31:0] pf_load_data, reg_wdata, reg_rdata;
	logic [31:0] rd_val; // Data of the last access
	logic [31:0] st_val; // Status after the last poll
	int fail_count, samples_checked, cyc, t0;
	eee_link link();
	eee_host u_eee_host (.sys_clk(sys_clk), .reset_n(reset_n), .link(link), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	eee_device #(.PROG_CYCLES(20), .ERASE_PROG_CYCLES(LONG_SIM)) u_eee_device (.sys_clk(sys_clk),
		.reset_n(reset_n), .link(link), .factory_blank(factory_blank), .pf_load_we(pf_load_we),
		.pf_load_addr(pf_load_addr), .pf_load_data(pf_load_data), .busy(busy));
	eee_link_properties #(.ERASE_PROG_CYCLES(LONG_SIM)) u_eee_link_properties (.sys_clk(sys_clk),
		.reset_n(reset_n), .bus_req(link.bus_req), .bus_wr(link.bus_wr), .bus_size(link.bus_size),
		.bus_addr(link.bus_addr), .bus_rsp(link.bus_rsp), .bus_err(link.bus_err),
		.cmd_valid(link.cmd_valid), .irq_en(link.irq_en), .cc_irq(link.cc_irq),
		.emulation_ready_flag(link.emulation_ready_flag),
		.command_complete_flag(link.command_complete_flag));
	// Compare one value, count it, report a mismatch
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask
	// One-cycle register write
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// One-cycle register read; data stands in the following cycle
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// Poll status until host idle and all mask bits set, bounded
	task automatic wait_st(input logic [31:0] mask);
		reg_read(eee_pkg::REG_STATUS, st_val);
		repeat (4000) if ((st_val & (mask | 32'h4)) !== mask) reg_read(eee_pkg::REG_STATUS, st_val);
		check(st_val & (mask | 32'h4), mask);
	endtask
	// Window or flash access through the host; code is size and write bit
	task automatic acc(input logic [31:0] a, input logic [31:0] d, input logic [2:0] code);
		reg_write(eee_pkg::REG_ADDR, a);
		reg_write(eee_pkg::REG_WDATA, d);
		reg_write(eee_pkg::REG_ACC, {29'h0, code});
		wait_st(32'h0);
		reg_read(eee_pkg::REG_RDATA, rd_val);
	endtask
	// Verdict and end of run
	task automatic close_out();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// System clock, 40 ns period
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// Free-running cycle count for store timing
	always @(posedge sys_clk) cyc <= cyc + 1;
	// Watchdog against a hang
	initial begin
		repeat (30000) @(posedge sys_clk);
		fail_count++;
		close_out();
	end
	// Main sequence
	initial begin
		{fail_count, samples_checked, cyc} = '0;
		{reset_n, pf_load_we, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		factory_blank = 1'b1;
		pf_load_addr = 10'h003;
		pf_load_data = 32'hcafe_0123;
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		pf_load_we <= 1'b1;
		@(posedge sys_clk);
		pf_load_we <= 1'b0;
		factory_blank <= 1'b0;
		wait_st(32'h2);
		check(st_val & 32'h1, 32'h0);
		reg_write(eee_pkg::REG_CFG, 32'h0010_0818);
		reg_write(eee_pkg::REG_CMD, {30'h0, eee_pkg::CMD_MASS_ERASE});
		wait_st(32'h2);
		reg_write(eee_pkg::REG_CMD, {30'h0, eee_pkg::CMD_PARTITION});
		wait_st(32'h13);
		acc(32'h1400_0000, 32'h1122_3344, 3'h5);
		acc(32'h1400_0001, 32'h0, 3'h0);
		check(rd_val, 32'h33);
		acc(32'h1400_0002, 32'h0, 3'h2);
		check(rd_val, 32'h1122);
		acc(32'h1400_001f, 32'hab, 3'h1);
		acc(32'h1400_001c, 32'h0, 3'h4);
		check(rd_val, 32'habff_ffff);
		acc(32'h1400_0020, 32'h0, 3'h4);
		check(st_val & 32'h8, 32'h8);
		acc(32'h1400_0020, 32'h5, 3'h5);
		check(st_val & 32'h8, 32'h8);
		acc(32'h1400_1000, 32'h0, 3'h4);
		check(st_val & 32'h8, 32'h8);
		// Program flash read while a long store runs
		acc(32'h1400_0000, 32'h1122_3344, 3'h5);
		acc(32'h0000_000c, 32'h0, 3'h4);
		check(rd_val, 32'hcafe_0123);
		check(st_val & 32'h9, 32'h0);
		// Store times: pre-erased location is short, rewritten one is long
		acc(32'h1400_0008, 32'hffff, 3'h3);
		wait_st(32'h3);
		t0 = cyc;
		acc(32'h1400_0008, 32'h1234, 3'h3);
		wait_st(32'h3);
		check({31'h0, (cyc - t0) < LONG_SIM}, 32'h1);
		t0 = cyc;
		acc(32'h1400_0008, 32'h5678, 3'h3);
		wait_st(32'h3);
		check({31'h0, (cyc - t0) >= LONG_SIM && (cyc - t0) < LONG_SIM + 30}, 32'h1);
		check({31'h0, busy}, 32'h0);
		// Second reset: configuration and data come back without a command
		reset_n <= 1'b0;
		@(posedge sys_clk);
		reset_n <= 1'b1;
		reg_read(eee_pkg::REG_STATUS, st_val);
		check(st_val & 32'h1, 32'h0);
		wait_st(32'h3);
		acc(32'h1400_0000, 32'h0, 3'h4);
		check(rd_val, 32'h1122_3344);
		acc(32'h1400_0008, 32'h0, 3'h2);
		check(rd_val, 32'h5678);
		reg_write(eee_pkg::REG_CMD, {30'h0, eee_pkg::CMD_MASS_ERASE});
		wait_st(32'h2);
		// Unconfigured: the host would wait for ready forever on a window access,
		// so a refused program flash write shows the error bit beside ready low
		acc(32'h0000_0000, 32'h0, 3'h5);
		check(st_val & 32'h9, 32'h8);
		close_out();
	end
endmodule // emulated_eeprom_access_tb

// [hw/eee_device.sv]
// Emulated EEPROM device: RAM window, backup flash store, boot reload
module eee_device #(
	parameter int PROG_CYCLES = eee_pkg::PROG_CYCLES,
	parameter int ERASE_PROG_CYCLES = eee_pkg::ERASE_PROG_CYCLES
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	eee_link.device link,
	input wire logic factory_blank,
	input wire logic pf_load_we,
	input wire logic [9:0] pf_load_addr,
	input wire logic [31:0] pf_load_data,
	output logic busy
);
	eee_pkg::dev_state_t state_reg; // Sequencer state
	eee_pkg::dev_state_t state_next;
	logic [eee_pkg::CFG_W-1:0] cfg_reg; // Working copy of the configuration
	logic [eee_pkg::CFG_W-1:0] cfg_next;
	logic [eee_pkg::CFG_W-1:0] nv_row_mem [0:0]; // Nonvolatile row, survives reset
	logic [7:0] ram_mem [0:eee_pkg::WIN_BYTES-1]; // RAM window
	logic [15:0] backup_mem [0:eee_pkg::HW_COUNT-1]; // Backup flash store
	logic [31:0] pf_mem [0:eee_pkg::PF_WORDS-1]; // Program flash
	logic [eee_pkg::HW_W-1:0] idx_reg; // Halfword walk index
	logic two_reg; // Record covers two halfwords
	logic [15:0] cnt_reg; // Program time counter
	logic reload_reg; // Reload configuration after erase
	logic ready_reg, cc_reg, irq_reg, busy_reg;
	logic rsp_reg, err_reg;
	logic [31:0] rdata_reg;
	// Decode helpers
	logic [eee_pkg::CFG_W-1:0] nv_cfg;
	logic [eee_pkg::CFG_W-1:0] new_cfg;
	logic [12:0] size_bytes;
	logic cfg_en, nv_en, en_next;
	logic in_win, in_pf, aligned, win_ok, pf_ok;
	logic [2:0] nbytes;
	logic [eee_pkg::OFF_W-1:0] off;
	logic [eee_pkg::HW_W-1:0] hw_idx;
	logic wr_accept, cmd_part_acc, cmd_erase_acc, discard, long_needed;
	logic boot_last, erase_last, prog_done;
	logic [31:0] rd_word;

	assign nv_cfg = nv_row_mem[0];
	assign new_cfg = {1'b1, link.cmd_size, link.cmd_split, link.cmd_part};
	assign size_bytes = cfg_reg[eee_pkg::CFG_SIZE_LSB +: eee_pkg::CFG_SIZE_W];
	assign cfg_en = cfg_reg[eee_pkg::CFG_VALID_BIT] && (size_bytes != 13'h0000);
	assign nv_en = nv_cfg[eee_pkg::CFG_VALID_BIT]
		&& (nv_cfg[eee_pkg::CFG_SIZE_LSB +: eee_pkg::CFG_SIZE_W] != 13'h0000);
	assign off = link.bus_addr[eee_pkg::OFF_W-1:0];
	assign hw_idx = off[eee_pkg::OFF_W-1:1];
	assign in_win = (link.bus_addr[31:26] == eee_pkg::WIN_REGION);
	assign in_pf = (link.bus_addr[31:26] == eee_pkg::PF_REGION);

	// Access width and natural alignment
	always_comb begin
		case (link.bus_size)
			eee_pkg::SZ_BYTE: begin
				nbytes = 3'h1;
				aligned = 1'b1;
			end
			eee_pkg::SZ_HALF: begin
				nbytes = 3'h2;
				aligned = (link.bus_addr[0] == 1'b0);
			end
			eee_pkg::SZ_WORD: begin
				nbytes = 3'h4;
				aligned = (link.bus_addr[1:0] == 2'h0);
			end
			default: begin
				nbytes = 3'h0;
				aligned = 1'b0;
			end
		endcase
	end

	assign win_ok = in_win && cfg_en && (state_reg == eee_pkg::ST_IDLE) && aligned
		&& (({1'b0, link.bus_addr[25:0]} + {24'h000000, nbytes})
		<= {14'h0000, size_bytes});
	assign pf_ok = in_pf && !link.bus_wr;
	assign wr_accept = link.bus_req && link.bus_wr && win_ok;
	assign cmd_part_acc = link.cmd_valid && (state_reg == eee_pkg::ST_IDLE)
		&& (link.cmd_code == eee_pkg::CMD_PARTITION);
	assign cmd_erase_acc = link.cmd_valid && (state_reg == eee_pkg::ST_IDLE)
		&& (link.cmd_code == eee_pkg::CMD_MASS_ERASE);
	assign discard = cfg_reg[eee_pkg::CFG_VALID_BIT] && (new_cfg != cfg_reg);
	assign long_needed = (backup_mem[hw_idx] != eee_pkg::ERASED_HALF)
		|| ((link.bus_size == eee_pkg::SZ_WORD)
		&& (backup_mem[hw_idx + 11'h001] != eee_pkg::ERASED_HALF));
	assign boot_last = ({1'b0, idx_reg} == (size_bytes[12:1] - 12'h001));
	assign erase_last = (idx_reg == eee_pkg::HW_LAST);
	assign prog_done = (cnt_reg == 16'h0000);

	// Next sequencer state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			eee_pkg::ST_LOAD: begin
				if (factory_blank) begin
					state_next = eee_pkg::ST_ERASE;
				end else if (nv_en) begin
					state_next = eee_pkg::ST_BOOT;
				end else begin
					state_next = eee_pkg::ST_IDLE;
				end
			end
			eee_pkg::ST_BOOT: begin
				if (boot_last) begin
					state_next = eee_pkg::ST_IDLE;
				end
			end
			eee_pkg::ST_IDLE: begin
				if (wr_accept) begin
					state_next = eee_pkg::ST_PROG;
				end else if (cmd_erase_acc || (cmd_part_acc && discard)) begin
					state_next = eee_pkg::ST_ERASE;
				end else if (cmd_part_acc) begin
					state_next = eee_pkg::ST_LOAD;
				end
			end
			eee_pkg::ST_PROG: begin
				if (prog_done) begin
					state_next = eee_pkg::ST_IDLE;
				end
			end
			eee_pkg::ST_ERASE: begin
				if (erase_last) begin
					state_next = reload_reg ? eee_pkg::ST_LOAD : eee_pkg::ST_IDLE;
				end
			end
			default: state_next = eee_pkg::ST_LOAD;
		endcase
	end

	// Next working configuration
	always_comb begin
		cfg_next = cfg_reg;
		if (state_reg == eee_pkg::ST_LOAD) begin
			cfg_next = factory_blank ? eee_pkg::CFG_BLANK : nv_cfg;
		end else if ((state_reg == eee_pkg::ST_ERASE) && erase_last && !reload_reg) begin
			cfg_next = eee_pkg::CFG_BLANK;
		end
	end
	assign en_next = cfg_next[eee_pkg::CFG_VALID_BIT]
		&& (cfg_next[eee_pkg::CFG_SIZE_LSB +: eee_pkg::CFG_SIZE_W] != 13'h0000);

	// Window read data, right-justified
	always_comb begin
		rd_word = 32'h00000000;
		for (int j = 0; j < 4; j++) begin
			if (3'(j) < nbytes) begin
				rd_word[8*j +: 8] = ram_mem[off + 12'(j)];
			end
		end
	end

	// Sequencer state register; reset restarts the configuration load
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= eee_pkg::ST_LOAD;
			cfg_reg <= eee_pkg::CFG_BLANK;
		end else begin
			state_reg <= state_next;
			cfg_reg <= cfg_next;
		end
	end

	// Walk index, record width and program timer
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			idx_reg <= 11'h000;
			two_reg <= 1'b0;
			cnt_reg <= 16'h0000;
			reload_reg <= 1'b0;
		end else begin
			case (state_reg)
				eee_pkg::ST_BOOT, eee_pkg::ST_ERASE: begin
					idx_reg <= idx_reg + 11'h001;
				end
				eee_pkg::ST_IDLE: begin
					if (wr_accept) begin
						idx_reg <= hw_idx;
						two_reg <= (link.bus_size == eee_pkg::SZ_WORD);
						cnt_reg <= long_needed ? 16'(ERASE_PROG_CYCLES - 1)
							: 16'(PROG_CYCLES - 1);
					end else begin
						idx_reg <= 11'h000;
						reload_reg <= cmd_part_acc;
					end
				end
				eee_pkg::ST_PROG: begin
					cnt_reg <= cnt_reg - 16'h0001;
				end
				eee_pkg::ST_LOAD: begin
					idx_reg <= 11'h000;
					reload_reg <= 1'b0;
				end
				default: idx_reg <= 11'h000;
			endcase
		end
	end

	// Nonvolatile configuration row
	always_ff @(posedge sys_clk) begin
		if (cmd_part_acc) begin
			nv_row_mem[0] <= new_cfg;
		end else if (cmd_erase_acc || ((state_reg == eee_pkg::ST_LOAD) && factory_blank)) begin
			nv_row_mem[0] <= eee_pkg::CFG_BLANK;
		end
	end

	// RAM window writes from the bus and from the boot copy
	always_ff @(posedge sys_clk) begin
		if (wr_accept) begin
			for (int j = 0; j < 4; j++) begin
				if (3'(j) < nbytes) begin
					ram_mem[off + 12'(j)] <= link.bus_wdata[8*j +: 8];
				end
			end
		end else if (state_reg == eee_pkg::ST_BOOT) begin
			ram_mem[{idx_reg, 1'b0}] <= backup_mem[idx_reg][7:0];
			ram_mem[{idx_reg, 1'b1}] <= backup_mem[idx_reg][15:8];
		end
	end

	// Backup store: record program and erase walk
	always_ff @(posedge sys_clk) begin
		if ((state_reg == eee_pkg::ST_PROG) && prog_done) begin
			backup_mem[idx_reg] <= {ram_mem[{idx_reg, 1'b1}], ram_mem[{idx_reg, 1'b0}]};
			if (two_reg) begin
				backup_mem[idx_reg + 11'h001] <= {ram_mem[{idx_reg + 11'h001, 1'b1}],
					ram_mem[{idx_reg + 11'h001, 1'b0}]};
			end
		end else if (state_reg == eee_pkg::ST_ERASE) begin
			backup_mem[idx_reg] <= eee_pkg::ERASED_HALF;
		end
	end

	// Program flash image load
	always_ff @(posedge sys_clk) begin
		if (pf_load_we) begin
			pf_mem[pf_load_addr] <= pf_load_data;
		end
	end

	// Bus answer one cycle after each request
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rsp_reg <= 1'b0;
			err_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			rsp_reg <= link.bus_req;
			err_reg <= link.bus_req && !(win_ok || pf_ok);
			if (link.bus_req && !link.bus_wr && pf_ok) begin
				rdata_reg <= pf_mem[link.bus_addr[11:2]];
			end else if (link.bus_req && !link.bus_wr && win_ok) begin
				rdata_reg <= rd_word;
			end else begin
				rdata_reg <= 32'h00000000;
			end
		end
	end

	// Status flags follow the next state
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ready_reg <= 1'b0;
			cc_reg <= 1'b0;
			irq_reg <= 1'b0;
			busy_reg <= 1'b1;
		end else begin
			// ready only when idle and loaded
			ready_reg <= (state_next == eee_pkg::ST_IDLE) && en_next;
			cc_reg <= (state_next == eee_pkg::ST_IDLE);
			irq_reg <= (state_next == eee_pkg::ST_IDLE) && link.irq_en;
			busy_reg <= (state_next != eee_pkg::ST_IDLE);
		end
	end

	assign link.bus_rsp = rsp_reg;
	assign link.bus_err = err_reg;
	assign link.bus_rdata = rdata_reg;
	assign link.emulation_ready_flag = ready_reg;
	assign link.command_complete_flag = cc_reg;
	assign link.cc_irq = irq_reg;
	assign busy = busy_reg;
endmodule // eee_device

// [hw/eee_host.sv]
// Host controller: register port to software, gated accesses on the link
module eee_host (
	input wire logic sys_clk,
	input wire logic reset_n,
	eee_link.host link,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);
	eee_pkg::host_state_t state_reg; // Sequencer state
	eee_pkg::host_state_t state_next;
	logic [20:0] cfg_reg; // Partition fields and interrupt enable
	logic [31:0] addr_reg, wdata_reg, rdata_reg, reg_rdata_reg;
	logic [1:0] size_reg, code_reg;
	logic wr_reg, op_cmd_reg, err_reg, erased_reg, req_reg, cmd_reg;
	logic start_acc, start_cmd, in_win, flags_ok;

	assign start_acc = reg_wr && (reg_addr == eee_pkg::REG_ACC) && (state_reg == eee_pkg::H_IDLE);
	assign start_cmd = reg_wr && (reg_addr == eee_pkg::REG_CMD) && (state_reg == eee_pkg::H_IDLE);
	assign in_win = (addr_reg[31:26] == eee_pkg::WIN_REGION);

	// Gate on device flags before launching
	always_comb begin
		if (op_cmd_reg) begin
			flags_ok = link.command_complete_flag;
		end else if (in_win) begin
			flags_ok = link.emulation_ready_flag && link.command_complete_flag;
		end else begin
			flags_ok = 1'b1;
		end
	end

	// Next sequencer state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			eee_pkg::H_IDLE: begin
				if (start_acc || start_cmd) begin
					state_next = eee_pkg::H_WAIT;
				end
			end
			eee_pkg::H_WAIT: begin
				if (flags_ok) begin
					state_next = eee_pkg::H_ISSUE;
				end
			end
			eee_pkg::H_ISSUE: state_next = eee_pkg::H_RESP;
			eee_pkg::H_RESP: state_next = eee_pkg::H_IDLE;
			default: state_next = eee_pkg::H_IDLE;
		endcase
	end

	// Sequencer and link strobes
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= eee_pkg::H_IDLE;
			req_reg <= 1'b0;
			cmd_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			req_reg <= (state_next == eee_pkg::H_ISSUE) && !op_cmd_reg;
			cmd_reg <= (state_next == eee_pkg::H_ISSUE) && op_cmd_reg
				&& ((code_reg != eee_pkg::CMD_PARTITION) || erased_reg);
		end
	end

	// Software registers and results
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_reg <= 21'h000000;
			addr_reg <= 32'h00000000;
			wdata_reg <= 32'h00000000;
			size_reg <= eee_pkg::SZ_BYTE;
			wr_reg <= 1'b0;
			code_reg <= 2'h0;
			op_cmd_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			err_reg <= 1'b0;
			erased_reg <= 1'b0;
		end else begin
			if (reg_wr && (reg_addr == eee_pkg::REG_CFG)) begin
				cfg_reg <= reg_wdata[20:0];
			end
			if (reg_wr && (reg_addr == eee_pkg::REG_ADDR) && (state_reg == eee_pkg::H_IDLE)) begin
				addr_reg <= reg_wdata;
			end
			if (reg_wr && (reg_addr == eee_pkg::REG_WDATA) && (state_reg == eee_pkg::H_IDLE)) begin
				wdata_reg <= reg_wdata;
			end
			if (start_acc) begin
				wr_reg <= reg_wdata[eee_pkg::ACC_WR_BIT];
				size_reg <= reg_wdata[eee_pkg::ACC_SIZE_LSB +: 2];
				op_cmd_reg <= 1'b0;
			end else if (start_cmd) begin
				code_reg <= reg_wdata[1:0];
				op_cmd_reg <= 1'b1;
			end
			if ((state_reg == eee_pkg::H_ISSUE) && op_cmd_reg) begin
				// Track erased state for later partitioning
				if (code_reg == eee_pkg::CMD_MASS_ERASE) begin
					erased_reg <= 1'b1;
				end else if (code_reg == eee_pkg::CMD_PARTITION) begin
					erased_reg <= 1'b0;
				end
				err_reg <= (code_reg == eee_pkg::CMD_PARTITION) && !erased_reg;
			end
			if ((state_reg == eee_pkg::H_RESP) && !op_cmd_reg) begin
				rdata_reg <= link.bus_rdata;
				err_reg <= link.bus_err;
			end
		end
	end

	// Register read data, one cycle after the strobe
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata_reg <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				eee_pkg::REG_CFG: reg_rdata_reg <= {11'h000, cfg_reg};
				eee_pkg::REG_ADDR: reg_rdata_reg <= addr_reg;
				eee_pkg::REG_WDATA: reg_rdata_reg <= wdata_reg;
				eee_pkg::REG_RDATA: reg_rdata_reg <= rdata_reg;
				eee_pkg::REG_STATUS: reg_rdata_reg <= {27'h0000000, link.cc_irq, err_reg,
					(state_reg != eee_pkg::H_IDLE), link.command_complete_flag,
					link.emulation_ready_flag};
				default: reg_rdata_reg <= 32'h00000000;
			endcase
		end else begin
			reg_rdata_reg <= 32'h00000000;
		end
	end

	assign link.bus_req = req_reg;
	assign link.bus_wr = wr_reg;
	assign link.bus_size = size_reg;
	assign link.bus_addr = addr_reg;
	assign link.bus_wdata = wdata_reg;
	assign link.cmd_valid = cmd_reg;
	assign link.cmd_code = code_reg;
	assign link.cmd_part = cfg_reg[3:0];
	assign link.cmd_split = cfg_reg[5:4];
	assign link.cmd_size = cfg_reg[18:6];
	assign link.irq_en = cfg_reg[eee_pkg::CFGR_IRQ_BIT];
	assign reg_rdata = reg_rdata_reg;
endmodule // eee_host

// [hw/eee_link.sv]
// Link between the processor-side host and the emulated EEPROM device
interface eee_link;
	logic bus_req; // Access request, one cycle
	logic bus_wr; // 1 write, 0 read
	logic [1:0] bus_size; // Byte, half or word
	logic [31:0] bus_addr; // Byte address
	logic [31:0] bus_wdata; // Right-justified write data
	logic bus_rsp; // Answer, one cycle after request
	logic bus_err; // Bus error with the answer
	logic [31:0] bus_rdata; // Right-justified read data
	logic cmd_valid; // Command launch, one cycle
	logic [1:0] cmd_code; // Partition or mass erase
	logic [12:0] cmd_size; // Emulated size in bytes
	logic [1:0] cmd_split; // Split factor
	logic [3:0] cmd_part; // Backup partition setting
	logic irq_en; // Command-complete interrupt enable
	logic emulation_ready_flag; // Emulated data loaded and idle
	logic command_complete_flag; // No flash operation running
	logic cc_irq; // Command-complete interrupt
	modport device (
		input bus_req, bus_wr, bus_size, bus_addr, bus_wdata,
		input cmd_valid, cmd_code, cmd_size, cmd_split, cmd_part, irq_en,
		output bus_rsp, bus_err, bus_rdata,
		output emulation_ready_flag, command_complete_flag, cc_irq
	);
	modport host (
		output bus_req, bus_wr, bus_size, bus_addr, bus_wdata,
		output cmd_valid, cmd_code, cmd_size, cmd_split, cmd_part, irq_en,
		input bus_rsp, bus_err, bus_rdata,
		input emulation_ready_flag, command_complete_flag, cc_irq
	);
endinterface

// [hw/eee_pkg.sv]
// Shared constants and types for the emulated EEPROM link and its two ends
package eee_pkg;
	// Address decode: bits 31:26 select the region
	localparam logic [5:0] WIN_REGION = 6'h05; // RAM window 0x1400_0000..0x17ff_ffff
	localparam logic [5:0] PF_REGION = 6'h00; // Program flash, read only
	localparam int OFF_W = 12; // Byte offset width inside the RAM window
	localparam int HW_W = 11; // Halfword index width of the backup store
	localparam int WIN_BYTES = 4096; // Largest emulated size in bytes
	localparam int HW_COUNT = 2048; // Backup halfwords
	localparam int PF_WORDS = 1024; // Program flash words
	localparam logic [HW_W-1:0] HW_LAST = 11'h7ff; // Last backup halfword
	localparam logic [15:0] ERASED_HALF = 16'hffff; // Erased flash contents
	// Access sizes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	// Commands
	localparam logic [1:0] CMD_PARTITION = 2'h1;
	localparam logic [1:0] CMD_MASS_ERASE = 2'h2;
	// Nonvolatile configuration word layout
	localparam int CFG_W = 20;
	localparam int CFG_VALID_BIT = 19;
	localparam int CFG_SIZE_LSB = 6;
	localparam int CFG_SIZE_W = 13;
	localparam int CFG_SPLIT_LSB = 4;
	localparam int CFG_PART_LSB = 0;
	localparam logic [CFG_W-1:0] CFG_BLANK = 20'h00000;
	// Timing
	localparam int CLK_MHZ = 25;
	localparam int PROG_TIME_US = 100; // Program of a pre-erased location
	localparam int ERASE_PROG_TIME_US = 1500; // Erase plus program, worst case
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	localparam int ERASE_PROG_CYCLES = ERASE_PROG_TIME_US * CLK_MHZ;
	// Host register offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_CFG = 8'h04;
	localparam logic [7:0] REG_ADDR = 8'h08;
	localparam logic [7:0] REG_WDATA = 8'h0c;
	localparam logic [7:0] REG_ACC = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_RDATA = 8'h18;
	// Host register fields
	localparam int CFGR_IRQ_BIT = 20;
	localparam int ACC_WR_BIT = 0;
	localparam int ACC_SIZE_LSB = 1;
	localparam int ST_READY_BIT = 0;
	localparam int ST_CC_BIT = 1;
	localparam int ST_BUSY_BIT = 2;
	localparam int ST_ERR_BIT = 3;
	localparam int ST_IRQ_BIT = 4;
	// Device sequencer states
	typedef enum logic [4:0] {
		ST_LOAD = 5'h01,
		ST_BOOT = 5'h02,
		ST_IDLE = 5'h04,
		ST_PROG = 5'h08,
		ST_ERASE = 5'h10
	} dev_state_t;
	// Host sequencer states
	typedef enum logic [3:0] {
		H_IDLE = 4'h1,
		H_WAIT = 4'h2,
		H_ISSUE = 4'h4,
		H_RESP = 4'h8
	} host_state_t;
endpackage
